// File: rtl/rx_frame_engine.sv
`timescale 1ns/1ns
`default_nettype none
module rx_frame_engine
  import uart_err_pkg::*;
(
  // clock and reset
  input  wire logic          mclk,
  input  wire logic          rst,
  // synchronised line and setup
  input  wire logic          rx_s,
  input  wire logic          par_en,
  input  wire logic [11:0]   div,
  // results
  output logic               start_p,
  output logic               done_p,
  output logic [7:0]         data,
  output err_flags_type      err
);

  rx_state_type st_r, st_nxt;       // frame state
  logic [11:0]  cnt_r, cnt_nxt;     // bit timer
  logic [3:0]   bit_r, bit_nxt;     // data bit index
  logic [7:0]   sh_r, sh_nxt;       // shift register
  logic         par_r, par_nxt;     // running parity
  logic         prev_r;             // line one cycle ago
  logic [15:0]  low_r, low_nxt;     // low run length
  logic         st_p, dn_p;         // next pulses
  logic         pe_p, fe_p, br_p;   // next error pulses
  wire          tick = (cnt_r == 12'h000);
  wire          fall = prev_r & ~rx_s;
  wire [15:0]   limit;

  // break threshold: one whole frame of bit times
  assign limit = 16'(div) *
    16'(par_en ? FRAME_BITS_PAR : FRAME_BITS_NOPR);

  // frame sequencer
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = tick ? cnt_r : cnt_r - 12'h001;
    bit_nxt = bit_r;
    sh_nxt  = sh_r;
    par_nxt = par_r;
    st_p = 1'b0;
    dn_p = 1'b0;
    pe_p = 1'b0;
    fe_p = 1'b0;
    unique case (st_r)
      RX_IDLE: if (fall) begin
        st_nxt  = RX_START;
        cnt_nxt = div >> 1;
        st_p    = 1'b1;
      end
      RX_START: if (tick) begin
        // glitch shorter than half a bit is dropped
        st_nxt  = rx_s ? RX_IDLE : RX_DATA;
        cnt_nxt = div - 12'h001;
        bit_nxt = 4'h0;
        par_nxt = 1'b0;
      end
      RX_DATA: if (tick) begin
        sh_nxt  = {rx_s, sh_r[7:1]};
        par_nxt = par_r ^ rx_s;
        bit_nxt = bit_r + 4'h1;
        cnt_nxt = div - 12'h001;
        if (bit_r == DATA_BITS_LAST) begin
          st_nxt = par_en ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR: if (tick) begin
        pe_p    = par_r ^ rx_s;
        cnt_nxt = div - 12'h001;
        st_nxt  = RX_STOP;
      end
      RX_STOP: if (tick) begin
        dn_p   = 1'b1;
        fe_p   = ~rx_s;
        st_nxt = rx_s ? RX_IDLE : RX_WAITH;
      end
      RX_WAITH: if (rx_s) begin
        st_nxt = RX_IDLE;
      end
    endcase
  end

  // low run counter, saturating, flags once per run
  assign low_nxt = rx_s ? 16'h0000 :
    (&low_r ? low_r : low_r + 16'h0001);
  assign br_p = ~rx_s & (low_r == limit);

  // state and result registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r    <= RX_IDLE;
      cnt_r   <= 12'h000;
      bit_r   <= 4'h0;
      sh_r    <= 8'h00;
      par_r   <= 1'b0;
      prev_r  <= 1'b1;
      low_r   <= 16'h0000;
      start_p <= 1'b0;
      done_p  <= 1'b0;
      data    <= 8'h00;
      err     <= '0;
    end else begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      bit_r   <= bit_nxt;
      sh_r    <= sh_nxt;
      par_r   <= par_nxt;
      prev_r  <= rx_s;
      low_r   <= low_nxt;
      start_p <= st_p;
      done_p  <= dn_p;
      data    <= dn_p ? sh_r : data;
      err     <= '{br_p, fe_p, pe_p, 1'b0};
    end
  end

endmodule // rx_frame_engine
`default_nettype wire

// File: rtl/uart_err_irq.sv
// Overview of operation
// - disable write of one turns interrupt off
// - receive events have own disable fields
// - transmit events have own disable fields
// - clear-to-send and error events disable fields
// - error source readable, write one clears
// - start bit with unread byte: overrun
// - parity mismatch sets parity flag when enabled
// - missing stop bit sets framing flag
// - line low beyond frame sets break
// - error flag reads one until cleared
// - enable write of one turns interrupt on
`timescale 1ns/1ns
`default_nettype none
module uart_err_irq
  import uart_err_pkg::*;
(
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // register port
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // serial receive line
  input  wire logic        rx_pin,
  // event pulses from the neighbouring parts
  input  wire logic [31:0] ext_events,
  // interrupt
  output logic             irq
);

  ////////////////////////////////////////////////////////
  // declarations
  ////////////////////////////////////////////////////////

  logic          rx_meta_r;   // first sync stage
  logic          rx_sync_r;   // second sync stage
  logic [31:0]   en_r;        // shared enable state
  logic [31:0]   en_nxt;
  logic [31:0]   stat_r;      // sticky event status
  logic [31:0]   stat_nxt;
  err_flags_type err_r;       // error source flags
  err_flags_type err_nxt;
  logic [7:0]    hold_r;      // receive holding stage
  logic          full_r;      // holding stage unread
  logic          full_nxt;
  logic [31:0]   cfg_r;       // parity and divisor
  logic [31:0]   rd_val;      // read mux output

  // receiver results
  logic          rx_start;
  logic          rx_done;
  logic [7:0]    rx_data;
  err_flags_type rx_err;

  ////////////////////////////////////////////////////////
  // address decode
  ////////////////////////////////////////////////////////

  // write strobes per register
  wire wr_set = reg_wr & (reg_addr == OFS_INT_SET);
  wire wr_dis = reg_wr & (reg_addr == OFS_INT_DIS);
  wire wr_err = reg_wr & (reg_addr == OFS_ERR_SRC);
  wire wr_cfg = reg_wr & (reg_addr == OFS_CONFIG);

  // read strobes with side effects
  wire rd_stat = reg_rd & (reg_addr == OFS_EVT_STAT);
  wire rd_rxd  = reg_rd & (reg_addr == OFS_RX_DATA);

  // only implemented fields respond
  wire [31:0] set_bits = wr_set ?
    (reg_wdata & INT_FIELDS) : WORD_RESET;
  wire [31:0] clr_bits = wr_dis ?
    (reg_wdata & INT_FIELDS) : WORD_RESET;
  wire [3:0]  err_clr  = wr_err ?
    reg_wdata[3:0] : 4'h0;

  // configuration fields
  wire        par_en = cfg_r[CFG_PAR_BIT];
  wire [11:0] div    = cfg_r[CFG_DIV_LSB +: 12];

  ////////////////////////////////////////////////////////
  // receive line synchroniser
  ////////////////////////////////////////////////////////

  // two stages before any logic looks at the pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end else begin
      rx_meta_r <= rx_pin;
      rx_sync_r <= rx_meta_r;
    end
  end

  ////////////////////////////////////////////////////////
  // frame receiver
  ////////////////////////////////////////////////////////

  rx_frame_engine u_rx (
    .mclk    (mclk),
    .rst     (rst),
    .rx_s    (rx_sync_r),
    .par_en  (par_en),
    .div     (div),
    .start_p (rx_start),
    .done_p  (rx_done),
    .data    (rx_data),
    .err     (rx_err)
  );

  ////////////////////////////////////////////////////////
  // error source
  ////////////////////////////////////////////////////////

  // start bit while previous byte unread
  wire ovr_hit = rx_start & full_r;

  // new error pulses this cycle
  wire [3:0] err_hit = {rx_err.brk, rx_err.framing,
                        rx_err.parity, ovr_hit};

  // any new error raises the error event
  wire err_evt = |err_hit;

  // write one clears, zero keeps, a set wins
  assign err_nxt = (err_r & ~err_clr) | err_hit;

  ////////////////////////////////////////////////////////
  // holding stage
  ////////////////////////////////////////////////////////

  // a finished byte fills it, a data read empties it
  assign full_nxt = rx_done | (full_r & ~rd_rxd);

  ////////////////////////////////////////////////////////
  // interrupt enable and status
  ////////////////////////////////////////////////////////

  // set and clear share one enable state
  assign en_nxt = (en_r | set_bits) & ~clr_bits;

  // internal sources join the neighbours' pulses
  wire [31:0] evt_in = ext_events
    | (32'(rx_done) << BIT_BYTE_RX)
    | (32'(err_evt) << BIT_ERROR);

  // read clears the sticky bits; an event wins
  assign stat_nxt = (rd_stat ? WORD_RESET : stat_r)
    | (evt_in & INT_FIELDS);

  ////////////////////////////////////////////////////////
  // read mux
  ////////////////////////////////////////////////////////

  // both enable offsets show enable state
  assign rd_val =
    (reg_addr == OFS_INT_SET)  ? en_r :
    (reg_addr == OFS_INT_DIS)  ? en_r :
    (reg_addr == OFS_ERR_SRC)  ? {28'h0, err_r} :
    (reg_addr == OFS_EVT_STAT) ? stat_r :
    (reg_addr == OFS_RX_DATA)  ? {24'h0, hold_r} :
    (reg_addr == OFS_CONFIG)   ? cfg_r :
    WORD_RESET; // unmapped reads as zero

  ////////////////////////////////////////////////////////
  // state registers
  ////////////////////////////////////////////////////////

  // control and status
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      en_r   <= WORD_RESET;
      stat_r <= WORD_RESET;
      err_r  <= '0;
      full_r <= 1'b0;
    end else begin
      en_r   <= en_nxt;
      stat_r <= stat_nxt;
      err_r  <= err_nxt;
      full_r <= full_nxt;
    end
  end

  // data and configuration
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hold_r <= 8'h00;
      cfg_r  <= CFG_RESET;
    end else begin
      hold_r <= rx_done ? rx_data : hold_r;
      cfg_r  <= wr_cfg ? reg_wdata : cfg_r;
    end
  end

  // outputs straight from flops
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= WORD_RESET;
      irq       <= 1'b0;
    end else begin
      reg_rdata <= reg_rd ? rd_val : WORD_RESET;
      irq       <= |(stat_nxt & en_nxt);
    end
  end

  ////////////////////////////////////////////////////////
  // assertions
  ////////////////////////////////////////////////////////

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // disabling the error event
  AST_DIS_ERROR: assert property (
    wr_dis && reg_wdata[BIT_ERROR]
    |=> !en_r[BIT_ERROR])
    else $error("error interrupt still enabled");

  // disabling byte received
  AST_DIS_RX: assert property (
    wr_dis && reg_wdata[BIT_BYTE_RX]
    |=> !en_r[BIT_BYTE_RX])
    else $error("byte rx interrupt still enabled");

  // disabling transmitter stopped
  AST_DIS_TX: assert property (
    wr_dis && reg_wdata[BIT_TX_STOP]
    |=> !en_r[BIT_TX_STOP])
    else $error("tx stop interrupt still enabled");

  // enable then read back through disable offset
  AST_SET_READ: assert property (
    wr_set && reg_wdata[BIT_RX_TMO] ##1 !reg_wr
    ##1 reg_rd && reg_addr == OFS_INT_DIS
    |=> reg_rdata[BIT_RX_TMO])
    else $error("enable not visible on read");

  // disable read shows cleared field
  AST_DIS_READ: assert property (
    wr_dis && reg_wdata[BIT_CTS] ##1 !reg_wr
    ##1 reg_rd && reg_addr == OFS_INT_DIS
    |=> !reg_rdata[BIT_CTS])
    else $error("disabled field reads as enabled");

  // zero writes change nothing
  AST_ZERO_KEEP: assert property (
    (wr_dis || wr_err) && reg_wdata == WORD_RESET && err_hit == 4'h0
    |=> $stable(en_r) && err_r == $past(err_r))
    else $error("zero write changed a field");

  // write one clears the flag without new error
  AST_ERR_CLR: assert property (
    wr_err && reg_wdata[ERR_FRAMING] && !rx_err.framing
    |=> !err_r.framing)
    else $error("framing flag not cleared");

  // overrun caught on start bit
  AST_OVERRUN: assert property (
    rx_start && full_r && !rd_rxd
    |=> err_r.overrun [*2] or (wr_err ##1 1'b1))
    else $error("overrun not recorded");

  // parity, framing and break pulses land in flags
  AST_PARITY: assert property (
    rx_err.parity |=> err_r.parity)
    else $error("parity flag not set");

  AST_FRAMING: assert property (
    rx_err.framing |=> err_r.framing)
    else $error("framing flag not set");

  // break only when the line was low two cycles before, then its flag sets
  AST_BREAK: assert property (
    rx_err.brk |-> $past(!rx_sync_r, 2) && err_evt
    ##1 err_r.brk)
    else $error("break flag not set");

  // error source read returns recorded flags
  AST_ERR_READ: assert property (
    reg_rd && reg_addr == OFS_ERR_SRC
    |=> reg_rdata == {28'h0, $past(err_r)})
    else $error("error source read mismatch");

  // errors raise the error event in status
  AST_ERR_EVT: assert property (
    |err_hit |=> stat_r[BIT_ERROR])
    else $error("error event not raised");

  // interrupt output follows status and enable
  AST_IRQ: assert property (
    irq == |(stat_r & en_r))
    else $error("interrupt level mismatch");

  // disable write drops exactly the ones written
  AST_DIS_ONLY: assert property (
    wr_dis
    |=> en_r == ($past(en_r) & ~($past(reg_wdata) & INT_FIELDS)))
    else $error("disable write touched other fields");

  // enable write turns on every implemented one written
  AST_EN_SET: assert property (
    wr_set
    |=> (en_r & $past(reg_wdata) & INT_FIELDS) == ($past(reg_wdata) & INT_FIELDS))
    else $error("enable write not applied");

  // write one clears only the flags written
  AST_ERR_W1C: assert property (
    wr_err && err_hit == 4'h0
    |=> err_r == ($past(err_r) & ~$past(err_clr)))
    else $error("error source clear mismatch");

  // overrun hit lands in its flag
  AST_OVR_SET: assert property (
    ovr_hit |=> err_r.overrun)
    else $error("overrun flag not set");

  // finished byte fills the holding stage
  AST_HOLD_FILL: assert property (
    rx_done |=> full_r && hold_r == $past(rx_data))
    else $error("holding stage not filled");

  // read data stands one cycle only, zero otherwise
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == WORD_RESET)
    else $error("read data outside read cycle");

  // main scenarios
  CVR_FRAME: cover property (rx_err.framing);
  CVR_BYTE:  cover property (rx_done ##1 full_r);
  CVR_OVR:   cover property (ovr_hit);
  CVR_BREAK: cover property (rx_err.brk);
  CVR_IRQ:   cover property (!irq ##1 irq);

endmodule // uart_err_irq
`default_nettype wire

// File: rtl/uart_err_pkg.sv
package uart_err_pkg;

  // register offsets on the plain register port
  localparam logic [11:0] OFS_INT_SET  = 12'h304;
  localparam logic [11:0] OFS_INT_DIS  = 12'h308;
  localparam logic [11:0] OFS_ERR_SRC  = 12'h480;
  localparam logic [11:0] OFS_EVT_STAT = 12'h100;
  localparam logic [11:0] OFS_RX_DATA  = 12'h518;
  localparam logic [11:0] OFS_CONFIG   = 12'h56c;

  // implemented event fields of enable, disable and status
  localparam logic [31:0] INT_FIELDS = 32'h005a0397;
  localparam logic [31:0] WORD_RESET = 32'h0000_0000;

  // event bit positions
  localparam int BIT_CTS       = 0;
  localparam int BIT_CLEAR_TO_SEND_DEASSERTED_EVENT      = 1;
  localparam int BIT_BYTE_RX   = 2;
  localparam int BIT_RXBUF_END = 4;
  localparam int BIT_BYTE_TX   = 7;
  localparam int BIT_TXBUF_END = 8;
  localparam int BIT_ERROR     = 9;
  localparam int BIT_RX_TMO    = 17;
  localparam int BIT_RX_START  = 19;
  localparam int BIT_TX_START  = 20;
  localparam int BIT_TX_STOP   = 22;

  // error flag positions
  localparam int ERR_OVERRUN = 0;
  localparam int ERR_PARITY  = 1;
  localparam int ERR_FRAMING = 2;
  localparam int ERR_BREAK   = 3;

  // configuration fields and reset values
  localparam int            CFG_PAR_BIT = 0;
  localparam int            CFG_DIV_LSB = 4;
  localparam logic [11:0]   DIV_RESET   = 12'h0ae;
  localparam logic [31:0]   CFG_RESET   = 32'h0000_0ae0;

  // frame geometry in bit times
  localparam logic [3:0] DATA_BITS_LAST  = 4'h7;
  localparam logic [3:0] FRAME_BITS_NOPR = 4'ha;
  localparam logic [3:0] FRAME_BITS_PAR  = 4'hb;

  // error flags, laid out as in the error source word
  typedef struct packed {
    logic brk;
    logic framing;
    logic parity;
    logic overrun;
  } err_flags_type;

  // receiver states
  typedef enum logic [5:0] {
    RX_IDLE  = 6'b000001,
    RX_START = 6'b000010,
    RX_DATA  = 6'b000100,
    RX_PAR   = 6'b001000,
    RX_STOP  = 6'b010000,
    RX_WAITH = 6'b100000
  } rx_state_type;

endpackage

// File: test/uart_err_irq_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
// bench top: register model and error model against the design
module uart_err_irq_tb_top;
  import uart_err_pkg::*;
  localparam int DIV = 8;           // short bit time in clocks
  logic        mclk, rst, irq;      // clock, reset, interrupt
  logic        reg_wr, reg_rd;      // strobes
  logic        rx_pin;              // serial line
  logic [11:0] reg_addr;            // register address
  logic [31:0] reg_wdata, reg_rdata;
  logic [31:0] ext_events;          // event pulses
  logic [31:0] en_m, err_m, rv, w;  // bench model state
  logic [7:0]  b;                   // last byte sent
  int          miscompares, cmp_count, cycles, n;

  // design and far-side model
  uart_err_irq u_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_pin(rx_pin), .ext_events(ext_events),
    .irq(irq));
  uart_line_model u_line (.mclk(mclk), .rx_pin(rx_pin));

  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial mclk = 1'b0;
  always #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      report_and_stop;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // compare tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t irq %b expected %b", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  // register port cycles
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    // data stands until the next edge
    @(posedge mclk);
    d = reg_rdata;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    rd(a, rv);
    chk_word(rv, e);
  endtask

  // one event pulse, then settle
  task automatic pulse(input logic [31:0] v);
    @(posedge mclk);
    ext_events <= v;
    @(posedge mclk);
    ext_events <= 32'h0000_0000;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // error word and interrupt after new flags, then clear status
  task automatic err_chk(input logic [31:0] add);
    err_m = err_m | add;
    rd_chk(OFS_ERR_SRC, err_m);
    chk_bit(irq, add != 32'h0000_0000);
    rd(OFS_EVT_STAT, rv);
    rd(OFS_RX_DATA, rv);
  endtask

  // random frame from the far side
  task automatic frame(input logic pen, input logic pflip, input logic stop);
    b = 8'($urandom);
    u_line.send(b, DIV, pen, pflip, stop);
  endtask

  // verdict
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0000_0000;
    ext_events = 32'h0000_0000;
    miscompares = 0;
    cmp_count = 0;
    cycles = 0;
    en_m = 32'h0000_0000;
    err_m = 32'h0000_0000;
    void'($urandom(32'hfb47aae1));
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    // reset values and an unmapped place
    rd_chk(OFS_INT_DIS, WORD_RESET);
    rd_chk(OFS_INT_SET, WORD_RESET);
    rd_chk(OFS_ERR_SRC, WORD_RESET);
    rd_chk(12'h7fc, 32'h0000_0000);
    $display("test reset done");
    // random enable and disable words
    for (int k = 0; k < 6; k++) begin
      w = $urandom;
      wr(OFS_INT_SET, w);
      en_m = en_m | (w & INT_FIELDS);
      rd_chk(OFS_INT_DIS, en_m);
      w = $urandom;
      wr(OFS_INT_DIS, w);
      en_m = en_m & ~w;
      rd_chk(OFS_INT_SET, en_m);
    end
    // every event field on its own
    for (int i = 0; i < 32; i++) begin
      if (INT_FIELDS[i]) begin
        wr(OFS_INT_SET, INT_FIELDS);
        wr(OFS_INT_DIS, 32'h1 << i);
        rd_chk(OFS_INT_DIS, INT_FIELDS & ~(32'h1 << i));
        wr(OFS_INT_DIS, 32'h0000_0000);
        rd_chk(OFS_INT_DIS, INT_FIELDS & ~(32'h1 << i));
      end
    end
    $display("test enable fields done");
    // masked event stays quiet, enabled event interrupts
    wr(OFS_INT_DIS, 32'h0000_0001);
    pulse(32'h0000_0001);
    chk_bit(irq, 1'b0);
    rd(OFS_EVT_STAT, rv);
    pulse(32'h0000_0080);
    chk_bit(irq, 1'b1);
    rd(OFS_EVT_STAT, rv);
    repeat (2) @(posedge mclk);
    #1 chk_bit(irq, 1'b0);
    $display("test interrupt done");
    // only the error event left enabled, short bit time
    wr(OFS_INT_DIS, INT_FIELDS ^ (32'h1 << BIT_ERROR));
    wr(OFS_CONFIG, DIV << CFG_DIV_LSB);
    frame(1'b0, 1'b0, 1'b1);
    rd_chk(OFS_RX_DATA, {24'h000000, b});
    frame(1'b0, 1'b0, 1'b1);
    frame(1'b0, 1'b0, 1'b1);
    err_chk(32'h0000_0001);
    // zero write keeps, one write clears
    wr(OFS_ERR_SRC, 32'h0000_0000);
    rd_chk(OFS_ERR_SRC, err_m);
    wr(OFS_ERR_SRC, 32'h0000_0001);
    err_m = 32'h0000_0000;
    rd_chk(OFS_ERR_SRC, err_m);
    frame(1'b0, 1'b0, 1'b0);
    err_chk(32'h0000_0004);
    wr(OFS_ERR_SRC, 32'h0000_0004);
    err_m = 32'h0000_0000;
    $display("test overrun and framing done");
    // parity good then bad
    wr(OFS_CONFIG, (DIV << CFG_DIV_LSB) | 32'h1);
    frame(1'b1, 1'b0, 1'b1);
    err_chk(32'h0000_0000);
    frame(1'b1, 1'b1, 1'b1);
    err_chk(32'h0000_0002);
    wr(OFS_ERR_SRC, 32'h0000_0002);
    err_m = 32'h0000_0000;
    $display("test parity done");
    // low runs just under and over one frame, both frame lengths
    for (int p = 1; p >= 0; p--) begin
      wr(OFS_CONFIG, (DIV << CFG_DIV_LSB) | p);
      n = (10 + p) * DIV;
      u_line.hold(1'b0, n - 2);
      u_line.hold(1'b1, 3 * DIV);
      err_chk(32'h0000_0004);
      u_line.hold(1'b0, n + 4);
      u_line.hold(1'b1, 3 * DIV);
      err_chk(32'h0000_0008);
      wr(OFS_ERR_SRC, 32'h0000_000f);
      err_m = 32'h0000_0000;
      rd_chk(OFS_ERR_SRC, err_m);
    end
    $display("test break done");
    report_and_stop;
  end
endmodule // uart_err_irq_tb_top
`default_nettype wire

// File: test/uart_line_model.sv
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////
// remote transmitter on the receive line, driven by the bench tasks
module uart_line_model (
  // clock
  input  wire logic mclk,
  // serial line
  output logic      rx_pin
);
  // line rests high between frames
  initial rx_pin = 1'b1;

  // hold one level for n clocks
  task automatic hold(input logic v, input int n);
    rx_pin <= v;
    repeat (n) @(posedge mclk);
  endtask

  // one frame, lsb first, optional even parity, stop level chosen
  task automatic send(input logic [7:0] b, input int div, input logic pen,
                      input logic pflip, input logic stop);
    hold(1'b0, div);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], div);
    end
    // parity bit, flipped on request
    if (pen) begin
      hold((^b) ^ pflip, div);
    end
    hold(stop, div);
    // idle gap so the receiver re-arms
    hold(1'b1, 2 * div);
  endtask
endmodule // uart_line_model
`default_nettype wire
